// ### src/eefm_pkg.sv
package eefm_pkg;
    localparam logic [7:0] ADDR_MASK_NV2 = 8'h80;
    localparam logic [7:0] ADDR_MASK_NV1 = 8'h81;
    localparam logic [7:0] ADDR_MASK_NV0 = 8'h82;
    localparam logic [7:0] ADDR_PACKET_OPTIONS_NV = 8'h83;
    localparam logic [7:0] ADDR_FLAGS2 = 8'hCD;
    localparam logic [7:0] ADDR_FLAGS1 = 8'hCE;
    localparam logic [7:0] ADDR_FLAGS0 = 8'hCF;
    localparam logic [7:0] ADDR_MASK2 = 8'hD0;
    localparam logic [7:0] ADDR_MASK1 = 8'hD1;
    localparam logic [7:0] ADDR_MASK0 = 8'hD2;
    localparam logic [7:0] ADDR_PACKET_OPTIONS = 8'hD3;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] NV_RESET = 8'h00;
    // byte1 bit positions
    localparam int B1_TX_DONE = 0;
    localparam int B1_RX_WAIT = 1;
    localparam int B1_PLAIN = 2;
    localparam int B1_SEQ_DEC = 3;
    localparam int B1_SEQ_SKIP = 4;
    localparam int B1_PAIRING = 5;
    localparam logic [7:0] B1_IMPL = 8'h3F;
    // one register access from the command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } eefm_req_s;
    // event strobes, one cycle each, except rx_pending, a level that the flag follows
    typedef struct packed {
        logic tx_done;
        logic ack_requested;
        logic ack_received;
        logic rx_pending;
        logic plain_rx;
        logic enc_rx;
        logic [15:0] enc_seq;
        logic pairing_start;
        logic serial_ovf;
        logic radio_ovf;
        logic reg_write_fail;
        logic ack_retry_exhausted;
        logic payload_crc_err;
        logic header_crc_err;
        logic ack_seq_err;
        logic bad_frame_kind;
    } eefm_evt_s;
endpackage

// ### src/eefm_top.sv
// What this block does
// - each exception sets its flag bit, which holds until cleared, except receive-waiting, which follows rx_pending
// - status output active when flag and mask both set and legacy mask zero
// - extended mask ignored for status while legacy mask is non-zero
// - reading a flag register changes no flag bit
// - flag register write stores AND of current contents and written byte
// - host writes never set flags; zero clears; some cleared by logic
// - transmit-done flag set after send, or after ack when ack requested
// - receive-waiting flag high while buffered bytes remain, cleared by itself
// - plain-packet flag set on unencrypted receive only when accepted
// - sequence-decrease flag set when encrypted sequence is lower than previous
// - sequence-skip flag set when encrypted sequence jumps by more than one
// - pairing-started flag set when pairing process begins
// - low byte bit0 serial overflow, bit1 radio buffer overflow
// - low byte bit2 set when a register write fails
// - low byte bit3 set when ack missing after maximum retries
// - low byte bit4 payload crc error, bit5 header crc error
// - low byte bit6 ack sequence error, bit7 unsupported frame kind
// - mask bits share byte offset and bit position with their flags
// - packet options stored but have no effect
// - volatile masks and options load from non-volatile copies at power-up
`timescale 1ns/10ps
`default_nettype none
module eefm_top (
    input wire logic clock,
    input wire logic rstn,
    input wire eefm_pkg::eefm_req_s req,
    input wire eefm_pkg::eefm_evt_s evt,
    input wire logic [7:0] legacy_event_mask,
    input wire logic accept_plain_packets,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic exception_status_output
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_n = rst_sync_reg;

    logic [7:0] flags_reg [3];
    logic [7:0] flags_next [3];
    logic [7:0] mask_reg [3];
    logic [7:0] mask_next [3];
    logic [7:0] mask_nv_reg [3];
    logic [7:0] mask_nv_next [3];
    logic [7:0] packet_options_reg, packet_options_next;
    logic [7:0] packet_options_nv_reg, packet_options_nv_next;
    logic [15:0] last_seq_reg, last_seq_next;
    logic seq_valid_reg, seq_valid_next;
    logic ack_wait_reg, ack_wait_next;
    logic load_reg, load_next;
    logic [7:0] rd_data_next;
    logic rd_valid_next;
    logic status_next;
    logic [7:0] set0, set1;
    logic [16:0] seq_plus1;

    always_comb begin
        seq_plus1 = {1'b0, last_seq_reg} + 17'h00001;
        set0 = {evt.bad_frame_kind, evt.ack_seq_err, evt.header_crc_err,
                evt.payload_crc_err, evt.ack_retry_exhausted,
                evt.reg_write_fail, evt.radio_ovf, evt.serial_ovf};
        set1 = 8'h00;
        // ack-requested sends wait for the ack before completing
        ack_wait_next = ack_wait_reg;
        if (evt.tx_done && evt.ack_requested && !evt.ack_received) begin
            ack_wait_next = 1'b1;
        end else if (evt.ack_received || evt.ack_retry_exhausted) begin
            ack_wait_next = 1'b0;
        end
        set1[eefm_pkg::B1_TX_DONE] = (evt.tx_done && (!evt.ack_requested || evt.ack_received))
            || (ack_wait_reg && evt.ack_received);
        set1[eefm_pkg::B1_PLAIN] = evt.plain_rx && accept_plain_packets;
        set1[eefm_pkg::B1_SEQ_DEC] = evt.enc_rx && seq_valid_reg
            && (evt.enc_seq < last_seq_reg);
        set1[eefm_pkg::B1_SEQ_SKIP] = evt.enc_rx && seq_valid_reg
            && ({1'b0, evt.enc_seq} > seq_plus1);
        set1[eefm_pkg::B1_PAIRING] = evt.pairing_start;
        last_seq_next = evt.enc_rx ? evt.enc_seq : last_seq_reg;
        seq_valid_next = seq_valid_reg || evt.enc_rx;
        load_next = 1'b0;
        packet_options_next = packet_options_reg;
        packet_options_nv_next = packet_options_nv_reg;
        for (int i = 0; i < 3; i++) begin
            flags_next[i] = flags_reg[i];
            mask_next[i] = mask_reg[i];
            mask_nv_next[i] = mask_nv_reg[i];
        end
        // host write first, then events OR in so a same-cycle event survives
        if (req.wr) begin
            if (req.addr == eefm_pkg::ADDR_FLAGS0) begin
                flags_next[0] = flags_reg[0] & req.data;
            end else if (req.addr == eefm_pkg::ADDR_FLAGS1) begin
                flags_next[1] = flags_reg[1] & req.data;
            end else if (req.addr == eefm_pkg::ADDR_FLAGS2) begin
                flags_next[2] = flags_reg[2] & req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK0) begin
                mask_next[0] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK1) begin
                mask_next[1] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK2) begin
                mask_next[2] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK_NV0) begin
                mask_nv_next[0] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK_NV1) begin
                mask_nv_next[1] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_MASK_NV2) begin
                mask_nv_next[2] = req.data;
            end else if (req.addr == eefm_pkg::ADDR_PACKET_OPTIONS) begin
                packet_options_next = req.data;
            end else if (req.addr == eefm_pkg::ADDR_PACKET_OPTIONS_NV) begin
                packet_options_nv_next = req.data;
            end
        end
        flags_next[0] = flags_next[0] | set0;
        flags_next[1] = (flags_next[1] | set1) & eefm_pkg::B1_IMPL;
        flags_next[1][eefm_pkg::B1_RX_WAIT] = evt.rx_pending;
        flags_next[2] = eefm_pkg::FLAGS_RESET;
        // one cycle after release the volatile copies take the nv values
        if (load_reg) begin
            for (int i = 0; i < 3; i++) begin
                mask_next[i] = mask_nv_reg[i];
            end
            packet_options_next = packet_options_nv_reg;
        end
        // reads are pure muxes; no flag is touched
        rd_valid_next = req.rd;
        rd_data_next = 8'h00;
        if (req.addr == eefm_pkg::ADDR_FLAGS0) begin
            rd_data_next = flags_reg[0];
        end else if (req.addr == eefm_pkg::ADDR_FLAGS1) begin
            rd_data_next = flags_reg[1];
        end else if (req.addr == eefm_pkg::ADDR_FLAGS2) begin
            rd_data_next = flags_reg[2];
        end else if (req.addr == eefm_pkg::ADDR_MASK0) begin
            rd_data_next = mask_reg[0];
        end else if (req.addr == eefm_pkg::ADDR_MASK1) begin
            rd_data_next = mask_reg[1];
        end else if (req.addr == eefm_pkg::ADDR_MASK2) begin
            rd_data_next = mask_reg[2];
        end else if (req.addr == eefm_pkg::ADDR_MASK_NV0) begin
            rd_data_next = mask_nv_reg[0];
        end else if (req.addr == eefm_pkg::ADDR_MASK_NV1) begin
            rd_data_next = mask_nv_reg[1];
        end else if (req.addr == eefm_pkg::ADDR_MASK_NV2) begin
            rd_data_next = mask_nv_reg[2];
        end else if (req.addr == eefm_pkg::ADDR_PACKET_OPTIONS) begin
            rd_data_next = packet_options_reg;
        end else if (req.addr == eefm_pkg::ADDR_PACKET_OPTIONS_NV) begin
            rd_data_next = packet_options_nv_reg;
        end
        if (!req.rd) begin
            rd_data_next = 8'h00;
        end
        // status follows registered flags and masks, one cycle behind
        status_next = (legacy_event_mask == 8'h00)
            && (|((flags_reg[0] & mask_reg[0]) | (flags_reg[1] & mask_reg[1])
                | (flags_reg[2] & mask_reg[2])));
    end

    // nv copies survive the module reset, only rstn clears them
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 3; i++) begin
                mask_nv_reg[i] <= eefm_pkg::NV_RESET;
            end
            packet_options_nv_reg <= eefm_pkg::NV_RESET;
        end else begin
            for (int i = 0; i < 3; i++) begin
                mask_nv_reg[i] <= mask_nv_next[i];
            end
            packet_options_nv_reg <= packet_options_nv_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                flags_reg[i] <= eefm_pkg::FLAGS_RESET;
                mask_reg[i] <= eefm_pkg::NV_RESET;
            end
            packet_options_reg <= eefm_pkg::NV_RESET;
            last_seq_reg <= 16'h0000;
            seq_valid_reg <= 1'b0;
            ack_wait_reg <= 1'b0;
            load_reg <= 1'b1;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            exception_status_output <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                flags_reg[i] <= flags_next[i];
                mask_reg[i] <= mask_next[i];
            end
            packet_options_reg <= packet_options_next;
            last_seq_reg <= last_seq_next;
            seq_valid_reg <= seq_valid_next;
            ack_wait_reg <= ack_wait_next;
            load_reg <= load_next;
            rd_data <= rd_data_next;
            rd_valid <= rd_valid_next;
            exception_status_output <= status_next;
        end
    end

    sequence serial_ovf_seen_s;
        evt.serial_ovf;
    endsequence
    sequence flag0_held_s;
        flags_reg[0][0] [*2];
    endsequence

    sticky_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        serial_ovf_seen_s |=> flag0_held_s)
        else $error("overflow flag not held");
    status_legacy_a: assert property (@(posedge clock) disable iff (!rst_n)
        (legacy_event_mask != 8'h00) |=> !exception_status_output)
        else $error("status active while legacy mask set");
    status_on_a: assert property (@(posedge clock) disable iff (!rst_n)
        ((legacy_event_mask == 8'h00) && (|(flags_reg[0] & mask_reg[0])))
        |=> exception_status_output)
        else $error("status not raised");
    read_noeffect_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.rd && !req.wr && set0 == 8'h00) |=> (flags_reg[0] == $past(flags_reg[0])))
        else $error("read changed flags");
    write_and_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && req.addr == eefm_pkg::ADDR_FLAGS0)
        |=> (flags_reg[0] == (($past(flags_reg[0]) & $past(req.data)) | $past(set0))))
        else $error("flag write not and");
    no_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && set0 == 8'h00) |=> ((flags_reg[0] & ~$past(flags_reg[0])) == 8'h00))
        else $error("write set a flag");
    rx_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> (flags_reg[1][eefm_pkg::B1_RX_WAIT] == $past(evt.rx_pending)))
        else $error("rx waiting flag wrong");
    plain_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!accept_plain_packets && !flags_reg[1][eefm_pkg::B1_PLAIN])
        |=> !flags_reg[1][eefm_pkg::B1_PLAIN])
        else $error("plain flag set while refused");
    top_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        flags_reg[2] == 8'h00)
        else $error("reserved flags set");
    mid_rsvd_a: assert property (@(posedge clock) disable iff (!rst_n)
        flags_reg[1][7:6] == 2'b00)
        else $error("unassigned middle flags set");

    // per-event set checks on the low byte
    serial_ovf_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.serial_ovf |=> flags_reg[0][0])
        else $error("serial overflow flag not set");
    radio_ovf_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.radio_ovf |=> flags_reg[0][1])
        else $error("radio overflow flag not set");
    wr_fail_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.reg_write_fail |=> flags_reg[0][2])
        else $error("write fail flag not set");
    no_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.ack_retry_exhausted |=> flags_reg[0][3])
        else $error("missing ack flag not set");
    payload_crc_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.payload_crc_err |=> flags_reg[0][4])
        else $error("payload crc flag not set");
    header_crc_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.header_crc_err |=> flags_reg[0][5])
        else $error("header crc flag not set");
    ack_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.ack_seq_err |=> flags_reg[0][6])
        else $error("ack sequence flag not set");
    frame_kind_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.bad_frame_kind |=> flags_reg[0][7])
        else $error("frame kind flag not set");

    // middle byte events
    sequence plain_send_s;
        evt.tx_done && !evt.ack_requested;
    endsequence
    sequence ack_pending_s;
        evt.tx_done && evt.ack_requested && !evt.ack_received
            && !flags_reg[1][eefm_pkg::B1_TX_DONE];
    endsequence
    tx_plain_a: assert property (@(posedge clock) disable iff (!rst_n)
        plain_send_s |=> flags_reg[1][eefm_pkg::B1_TX_DONE])
        else $error("tx done flag not set");
    tx_ack_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        ack_pending_s |=> !flags_reg[1][eefm_pkg::B1_TX_DONE])
        else $error("tx done flag set before ack");
    plain_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        (evt.plain_rx && accept_plain_packets) |=> flags_reg[1][eefm_pkg::B1_PLAIN])
        else $error("plain flag not set");
    seq_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
        (evt.enc_rx && seq_valid_reg && (evt.enc_seq < last_seq_reg))
        |=> flags_reg[1][eefm_pkg::B1_SEQ_DEC])
        else $error("sequence decrease flag not set");
    seq_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
        (evt.enc_rx && seq_valid_reg && ({1'b0, evt.enc_seq} > seq_plus1))
        |=> flags_reg[1][eefm_pkg::B1_SEQ_SKIP])
        else $error("sequence skip flag not set");
    seq_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        (evt.enc_rx && seq_valid_reg && ({1'b0, evt.enc_seq} == seq_plus1)
            && !flags_reg[1][eefm_pkg::B1_SEQ_SKIP])
        |=> !flags_reg[1][eefm_pkg::B1_SEQ_SKIP])
        else $error("sequence skip on step of one");
    pairing_a: assert property (@(posedge clock) disable iff (!rst_n)
        evt.pairing_start |=> flags_reg[1][eefm_pkg::B1_PAIRING])
        else $error("pairing flag not set");
    clear_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && req.addr == eefm_pkg::ADDR_FLAGS1 && !req.data[eefm_pkg::B1_TX_DONE]
            && !set1[eefm_pkg::B1_TX_DONE])
        |=> !flags_reg[1][eefm_pkg::B1_TX_DONE])
        else $error("zero write did not clear");

    // read path and status
    rd_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd |=> rd_valid)
        else $error("read not answered");
    rd_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.rd && req.addr == eefm_pkg::ADDR_FLAGS0) |=> (rd_data == $past(flags_reg[0])))
        else $error("flag read data wrong");
    rd_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
        !rd_valid |-> (rd_data == 8'h00))
        else $error("read data without valid");
    status_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        (((flags_reg[0] & mask_reg[0]) | (flags_reg[1] & mask_reg[1])
            | (flags_reg[2] & mask_reg[2])) == 8'h00) |=> !exception_status_output)
        else $error("status active without masked flag");

    // stored registers
    mask_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && req.addr == eefm_pkg::ADDR_MASK1 && !load_reg)
        |=> (mask_reg[1] == $past(req.data)))
        else $error("mask write lost");
    packet_options_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        (req.wr && req.addr == eefm_pkg::ADDR_PACKET_OPTIONS && !load_reg)
        |=> (packet_options_reg == $past(req.data)))
        else $error("packet options write lost");
    nv_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        load_reg |=> (mask_reg[0] == $past(mask_nv_reg[0])))
        else $error("mask not loaded from nv copy");
    reset_clear_a: assert property (@(posedge clock)
        $rose(rst_n) |-> ((flags_reg[0] == 8'h00) && !exception_status_output))
        else $error("flags not clear after reset");
endmodule // eefm_top
`default_nettype wire

// ### verif/eefm_host.sv
`timescale 1ns/10ps
`default_nettype none
module eefm_host (
    input wire logic clock,
    output var eefm_pkg::eefm_req_s req
);
    logic [7:0] exp_q[$];
    initial req = '0;
    // one access per call, held across exactly one sampling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req <= '{wr: w, rd: !w, addr: a, data: d};
        @(negedge clock);
        // released bus shows the inverse so a stale value cannot pass
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == eefm_pkg::ADDR_MASK2 || a == eefm_pkg::ADDR_MASK_NV2) v = 8'h00;
        if (a == eefm_pkg::ADDR_MASK1 || a == eefm_pkg::ADDR_MASK_NV1) v = v & 8'h3F;
        acc(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
endmodule // eefm_host
`default_nettype wire

// ### verif/eefm_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eefm_top_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    eefm_pkg::eefm_req_s req;
    eefm_pkg::eefm_evt_s evt = '0;
    eefm_pkg::eefm_evt_s e;
    logic [7:0] legacy_event_mask = 8'h00;
    logic accept_plain_packets = 1'b0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic exception_status_output;
    logic rxp = 1'b0;
    logic [7:0] r;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    integer seed = 32'hb5a93f86;
    always #20 clock = ~clock;
    eefm_host host (.clock(clock), .req(req));
    eefm_top dut (.clock(clock), .rstn(rstn), .req(req), .evt(evt),
        .legacy_event_mask(legacy_event_mask), .accept_plain_packets(accept_plain_packets),
        .rd_data(rd_data), .rd_valid(rd_valid), .exception_status_output(exception_status_output));
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic pulse(input eefm_pkg::eefm_evt_s p);
        @(negedge clock);
        evt = p;
        evt.rx_pending = rxp;
        @(negedge clock);
        evt = '0;
        evt.rx_pending = rxp;
    endtask
    function automatic eefm_pkg::eefm_evt_s lo(input logic [7:0] b);
        eefm_pkg::eefm_evt_s p;
        p = '0;
        {p.bad_frame_kind, p.ack_seq_err, p.header_crc_err, p.payload_crc_err,
            p.ack_retry_exhausted, p.reg_write_fail, p.radio_ovf, p.serial_ovf} = b;
        return p;
    endfunction
    task automatic st(input logic x);
        repeat (3) @(negedge clock);
        chk("status", {7'h00, exception_status_output}, {7'h00, x});
    endtask
    always @(negedge clock) begin
        if (rd_valid === 1'b1) begin
            if (host.exp_q.size() == 0) chk("rd_extra", 8'h01, 8'h00);
            else chk("rd_data", rd_data, host.exp_q.pop_front());
        end
    end
    // whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (6) @(negedge clock);
        host.rd(8'hCF, 8'h00);
        host.rd(8'hCE, 8'h00);
        host.rd(eefm_pkg::ADDR_MASK0, 8'h00);
        st(1'b0);
        r = 8'($random(seed));
        host.wr(eefm_pkg::ADDR_MASK_NV0, r);
        host.rd(eefm_pkg::ADDR_MASK_NV0, r);
        host.wr(eefm_pkg::ADDR_PACKET_OPTIONS, ~r);
        host.rd(eefm_pkg::ADDR_PACKET_OPTIONS, ~r);
        host.wr(eefm_pkg::ADDR_FLAGS2, 8'hFF);
        host.rd(eefm_pkg::ADDR_FLAGS2, 8'h00);
        host.rd(8'h90, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            pulse(lo(8'h01 << i));
            host.rd(8'hCF, 8'((2 << i) - 1));
        end
        host.rd(8'hCF, 8'hFF);
        host.wr(8'hCF, 8'hF0);
        host.rd(8'hCF, 8'hF0);
        host.wr(8'hCF, 8'hFF);
        host.rd(8'hCF, 8'hF0);
        fork
            host.wr(8'hCF, 8'h00);
            pulse(lo(8'h01));
        join
        host.rd(8'hCF, 8'h01);
        host.wr(eefm_pkg::ADDR_MASK0, 8'h01);
        st(1'b1);
        legacy_event_mask = 8'($random(seed)) | 8'h01;
        st(1'b0);
        legacy_event_mask = 8'h00;
        st(1'b1);
        host.wr(eefm_pkg::ADDR_MASK0, 8'h00);
        st(1'b0);
        $display("test low byte done");
        e = '0;
        e.tx_done = 1'b1;
        e.ack_requested = 1'b1;
        pulse(e);
        host.rd(8'hCE, 8'h00);
        e = '0;
        e.ack_received = 1'b1;
        pulse(e);
        host.rd(8'hCE, 8'h01);
        rxp = 1'b1;
        pulse('0);
        host.rd(8'hCE, 8'h03);
        rxp = 1'b0;
        pulse('0);
        host.rd(8'hCE, 8'h01);
        e = '0;
        e.plain_rx = 1'b1;
        pulse(e);
        host.rd(8'hCE, 8'h01);
        accept_plain_packets = 1'b1;
        pulse(e);
        host.rd(8'hCE, 8'h05);
        e = '0;
        e.enc_rx = 1'b1;
        e.enc_seq = 16'h0005;
        pulse(e);
        e.enc_seq = 16'h0003;
        pulse(e);
        host.rd(8'hCE, 8'h0D);
        e.enc_seq = 16'h000A;
        pulse(e);
        host.rd(8'hCE, 8'h1D);
        e = '0;
        e.pairing_start = 1'b1;
        pulse(e);
        host.rd(8'hCE, 8'h3D);
        // host model trims the unassigned mask bits to zero
        host.wr(eefm_pkg::ADDR_MASK1, 8'hE0);
        host.rd(eefm_pkg::ADDR_MASK1, 8'h20);
        st(1'b1);
        host.wr(8'hCE, 8'hDF);
        st(1'b0);
        host.rd(8'hCE, 8'h1D);
        $display("test middle byte done");
        repeat (4) @(negedge clock);
        chk("rd_missing", 8'(host.exp_q.size()), 8'h00);
        stop_test();
    end
endmodule // eefm_top_bench
`default_nettype wire
